/* srss_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module srss_asserts (
   input wire logic sys_clk,
   input wire logic reset,
   input wire srss_pkg::srss_io_req_t io_req,
   input wire logic ext_regs_unlocked,
   input wire logic [15:0] io_rdata,
   input wire logic io_rdata_valid,
   input wire logic [5:0] nmi_source_enables,
   input wire logic [5:0] local_attention_enables,
   input wire logic [5:0] nmi_cause_flags,
   input wire logic nmi_request,
   input wire srss_pkg::srss_port_view_t port_view
);
   // ***************************************************************
   // Checks.
   // ***************************************************************
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   wire logic unl = ext_regs_unlocked;
   wire logic rd_st = io_req.rd && unl &&
      io_req.addr == srss_pkg::SRSS_NMI_CAUSE_STATUS_ADDR;
   wire logic rd_pv = io_req.rd && unl &&
      io_req.addr == srss_pkg::SRSS_PORT_SHADOW_ADDR;
   wire logic rd_ic = io_req.rd && unl &&
      io_req.addr == srss_pkg::SRSS_IRQ_SHADOW_ADDR;
   wire logic rd_rtc = io_req.rd &&
      io_req.addr == srss_pkg::SRSS_RTC_SHADOW_ADDR;
   wire logic rd_bad = io_req.rd && !(rd_st || rd_pv || rd_ic || rd_rtc);
   wire logic [5:0] en_any = nmi_source_enables | local_attention_enables;

   a_rtc_read_answered: assert property (rd_rtc |=> io_rdata_valid)
      else $error("clock port shadow read not answered");
   a_refused_read_quiet: assert property (rd_bad |=>
      !io_rdata_valid && io_rdata == 16'h0000)
      else $error("refused read was answered");
   a_status_layout: assert property (rd_st |=>
      io_rdata == {8'h00, $past(nmi_cause_flags), 2'h0})
      else $error("status register image wrong");
   a_port_view_live: assert property (rd_pv |=>
      io_rdata == $past(port_view))
      else $error("port shadow image wrong");
   a_valid_has_read: assert property (io_rdata_valid |-> $past(io_req.rd))
      else $error("read valid without a read");
   a_rdata_holds: assert property (!$past(io_req.rd) |-> $stable(io_rdata))
      else $error("read data changed without a read");
   a_flag_needs_enable: assert property (
      (nmi_cause_flags & ~$past(nmi_cause_flags) &
       ~$past(nmi_source_enables)) == 6'h00)
      else $error("cause flag set without its enable");
   a_flag_held_enabled: assert property (
      ($past(nmi_cause_flags) & ~nmi_cause_flags & $past(en_any)) == 6'h00)
      else $error("cause flag dropped while enabled");
   a_flag_cleared_off: assert property (
      (nmi_cause_flags & ~$past(en_any)) == 6'h00)
      else $error("cause flag kept after enables cleared");
   a_request_is_or: assert property (nmi_request == |nmi_cause_flags)
      else $error("interrupt request does not match flags");

   c_rtc_read: cover property (rd_rtc ##1 io_rdata_valid);
   c_nmi_rise: cover property ($rose(nmi_request));
   c_nmi_fall: cover property ($fell(nmi_request));
endmodule : srss_asserts

bind srss_top srss_asserts u_asserts (.sys_clk, .reset, .io_req,
   .ext_regs_unlocked, .io_rdata, .io_rdata_valid, .nmi_source_enables,
   .local_attention_enables, .nmi_cause_flags, .nmi_request, .port_view);

`default_nettype wire

/* srss_cause_latch.sv */
`timescale 1ns/1ps
`default_nettype none

module srss_cause_latch #(
   parameter bit ACTIVE_EDGE_ONLY = 1'b0
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic pm_input,
   input wire logic nmi_enable,
   input wire logic attn_enable,
   output logic cause_flag,
   output logic attn_flag,
   output logic input_status
);

   // ***************************************************************
   // Transition detection.
   // ***************************************************************
   logic pin_prev_reg;
   logic cause_reg;
   logic cause_next;
   logic attn_reg;
   logic attn_next;
   logic status_reg;
   logic status_next;
   wire logic rise = pm_input & ~pin_prev_reg;
   wire logic change = pm_input ^ pin_prev_reg;
   wire logic event_seen = ACTIVE_EDGE_ONLY ? rise : change;
   wire logic latching = nmi_enable | attn_enable;
   wire logic release_all = ~nmi_enable & ~attn_enable;

   // ***************************************************************
   // Flag and status next values; a new event wins over release.
   // ***************************************************************
   assign cause_next = (nmi_enable & event_seen) ? 1'b1 :
      (release_all ? 1'b0 : cause_reg);
   assign attn_next = (attn_enable & event_seen) ? 1'b1 :
      (release_all ? 1'b0 : attn_reg);
   assign status_next = latching ? (status_reg | event_seen) : pm_input;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pin_prev_reg <= 1'b0;
         cause_reg <= 1'b0;
         attn_reg <= 1'b0;
         status_reg <= 1'b0;
      end else begin
         pin_prev_reg <= pm_input;
         cause_reg <= cause_next;
         attn_reg <= attn_next;
         status_reg <= status_next;
      end
   end

   assign cause_flag = cause_reg;
   assign attn_flag = attn_reg;
   assign input_status = status_reg;

endmodule : srss_cause_latch

`default_nettype wire

/* srss_pkg.sv */
package srss_pkg;

   // ***************************************************************
   // I/O port addresses.
   // ***************************************************************
   localparam logic [15:0] SRSS_NMI_CAUSE_STATUS_ADDR = 16'h9072;
   localparam logic [15:0] SRSS_PORT_SHADOW_ADDR = 16'hD072;
   localparam logic [15:0] SRSS_IRQ_SHADOW_ADDR = 16'hD472;
   localparam logic [15:0] SRSS_RTC_SHADOW_ADDR = 16'hE472;
   localparam logic [15:0] SRSS_RTC_INDEX_IO_ADDR = 16'h0070;

   // ***************************************************************
   // Reset values.
   // ***************************************************************
   localparam logic [7:0] SRSS_RTC_INDEX_RESET = 8'h80;
   localparam logic [3:0] SRSS_RTC_RESERVED_RESET = 4'h0;
   // The identification value is arbitrary.
   localparam logic [1:0] SRSS_DEVICE_IDENT_DEFAULT = 2'h1;

   // ***************************************************************
   // Field positions.
   // ***************************************************************
   localparam int SRSS_NMI_FLAGS_LSB = 2;
   localparam int SRSS_IRQ_TIMEOUT_BIT = 15;
   localparam int SRSS_IRQ_IDENT_LSB = 13;
   localparam int SRSS_IRQ_MVEC_BIT = 12;
   localparam int SRSS_IRQ_SVEC_BIT = 11;
   localparam int SRSS_IRQ_SPECIAL_NESTED_MIRROR_BIT = 10;
   localparam int SRSS_IRQ_AEOI_BIT = 9;
   localparam int SRSS_IRQ_RAEOI_BIT = 8;
   localparam int SRSS_IRQ_MPRI_LSB = 5;
   localparam int SRSS_IRQ_SPRI_LSB = 2;
   localparam int SRSS_IRQ_MSMM_BIT = 1;
   localparam int SRSS_IRQ_SSMM_BIT = 0;
   localparam int SRSS_ICW4_SPECIAL_NESTED_MIRROR_BIT = 4;
   localparam int SRSS_ICW4_AEOI_BIT = 1;
   localparam int SRSS_VECTOR_MSB_BIT = 7;

   // ***************************************************************
   // Interrupt controller command codes.
   // ***************************************************************
   localparam logic [2:0] SRSS_OCW2_ROT_AEOI_SET = 3'h4;
   localparam logic [2:0] SRSS_OCW2_ROT_AEOI_CLR = 3'h0;
   localparam logic [1:0] SRSS_OCW2_PRIORITY_CMD = 2'h3;
   localparam logic [1:0] SRSS_OCW3_SMM_SET = 2'h3;
   localparam logic [1:0] SRSS_OCW3_SMM_CLR = 2'h2;

   // ***************************************************************
   // Timing.
   // ***************************************************************
   localparam int SRSS_CLK_MHZ = 250;
   localparam int SRSS_NO_DMA_WINDOW_NS = 30500;
   localparam int SRSS_NO_DMA_CYCLES =
      (SRSS_NO_DMA_WINDOW_NS * SRSS_CLK_MHZ + 999) / 1000;

   // ***************************************************************
   // Carriers.
   // ***************************************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } srss_io_req_t;

   typedef struct packed {
      logic icw2_wr;
      logic icw4_wr;
      logic ocw2_wr;
      logic ocw3_wr;
      logic [7:0] data;
   } srss_pic_wr_t;

   typedef struct packed {
      logic [1:0] serial_a_reg2_mirror;
      logic [1:0] serial_b_reg2_mirror;
      logic [3:0] parallel_reg2_mirror;
      logic [7:0] parallel_reg0_mirror;
   } srss_port_view_t;

endpackage : srss_pkg

/* srss_top.sv */
`timescale 1ns/1ps
`default_nettype none

module srss_top #(
   parameter int NO_DMA_CYCLES = srss_pkg::SRSS_NO_DMA_CYCLES,
   parameter logic [1:0] DEVICE_IDENT = srss_pkg::SRSS_DEVICE_IDENT_DEFAULT
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire srss_pkg::srss_io_req_t io_req,
   input wire logic ext_regs_unlocked,
   output logic [15:0] io_rdata,
   output logic io_rdata_valid,
   input wire logic [5:0] pm_inputs,
   input wire logic [5:0] nmi_source_enables,
   input wire logic [5:0] local_attention_enables,
   output logic [5:0] nmi_cause_flags,
   output logic [5:0] local_attention_flags,
   output logic [5:0] pm_input_status,
   output logic nmi_request,
   output logic local_attention_request,
   input wire srss_pkg::srss_port_view_t port_view,
   input wire srss_pkg::srss_pic_wr_t pic_master_wr,
   input wire srss_pkg::srss_pic_wr_t pic_slave_wr,
   input wire logic idle_timeout_compare,
   input wire logic refresh_ref_input,
   input wire logic refresh_cycle,
   input wire logic cpu_irq_level,
   input wire logic bus_master_cycle
);

   // ***************************************************************
   // Parameter checks.
   // ***************************************************************
   if (NO_DMA_CYCLES < 1 || NO_DMA_CYCLES > 65535) begin : g_bad_window
      $error("NO_DMA_CYCLES must lie between 1 and 65535.");
   end

   // ***************************************************************
   // Power-management input cause latches.
   // ***************************************************************
   for (genvar i = 0; i < 6; i++) begin : g_cause
      srss_cause_latch #(
         .ACTIVE_EDGE_ONLY(i == 5)
      ) u_latch (
         .sys_clk(sys_clk),
         .reset(reset),
         .pm_input(pm_inputs[i]),
         .nmi_enable(nmi_source_enables[i]),
         .attn_enable(local_attention_enables[i]),
         .cause_flag(nmi_cause_flags[i]),
         .attn_flag(local_attention_flags[i]),
         .input_status(pm_input_status[i])
      );
   end

   // ***************************************************************
   // Interrupt requests to the processor side.
   // ***************************************************************
   assign nmi_request = |nmi_cause_flags;
   assign local_attention_request = |local_attention_flags;

   // ***************************************************************
   // Interrupt controller mirrors, one set per controller.
   // ***************************************************************
   srss_pkg::srss_pic_wr_t pic_wr [2];
   wire logic [1:0] vector_msb;
   wire logic [1:0] special_mask;
   wire logic [2:0] lowest_priority [2];
   logic special_nested_mirror_reg;
   logic auto_eoi_mirror_reg;
   logic rotate_auto_eoi_mirror_reg;

   assign pic_wr[0] = pic_master_wr;
   assign pic_wr[1] = pic_slave_wr;

   for (genvar c = 0; c < 2; c++) begin : g_pic
      wire logic [7:0] d = pic_wr[c].data;
      wire logic prio_cmd =
         pic_wr[c].ocw2_wr && d[7:6] == srss_pkg::SRSS_OCW2_PRIORITY_CMD;
      wire logic smm_set =
         pic_wr[c].ocw3_wr && d[6:5] == srss_pkg::SRSS_OCW3_SMM_SET;
      wire logic smm_clr =
         pic_wr[c].ocw3_wr && d[6:5] == srss_pkg::SRSS_OCW3_SMM_CLR;
      logic vector_msb_reg;
      logic [2:0] lowest_priority_reg;
      logic special_mask_reg;

      always_ff @(posedge sys_clk) begin
         if (reset) begin
            vector_msb_reg <= 1'b0;
            lowest_priority_reg <= 3'h0;
            special_mask_reg <= 1'b0;
         end else begin
            if (pic_wr[c].icw2_wr) begin
               vector_msb_reg <= d[srss_pkg::SRSS_VECTOR_MSB_BIT];
            end
            if (prio_cmd) begin
               lowest_priority_reg <= d[2:0];
            end
            if (smm_set) begin
               special_mask_reg <= 1'b1;
            end else if (smm_clr) begin
               special_mask_reg <= 1'b0;
            end
         end
      end

      assign vector_msb[c] = vector_msb_reg;
      assign lowest_priority[c] = lowest_priority_reg;
      assign special_mask[c] = special_mask_reg;
   end

   // ***************************************************************
   // Master-only mirrors; the slave settings are not kept.
   // ***************************************************************
   wire logic [2:0] master_ocw2_cmd = pic_master_wr.data[7:5];
   wire logic raeoi_set = pic_master_wr.ocw2_wr &&
      master_ocw2_cmd == srss_pkg::SRSS_OCW2_ROT_AEOI_SET;
   wire logic raeoi_clr = pic_master_wr.ocw2_wr &&
      master_ocw2_cmd == srss_pkg::SRSS_OCW2_ROT_AEOI_CLR;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         special_nested_mirror_reg <= 1'b0;
         auto_eoi_mirror_reg <= 1'b0;
      end else if (pic_master_wr.icw4_wr) begin
         special_nested_mirror_reg <=
            pic_master_wr.data[srss_pkg::SRSS_ICW4_SPECIAL_NESTED_MIRROR_BIT];
         auto_eoi_mirror_reg <=
            pic_master_wr.data[srss_pkg::SRSS_ICW4_AEOI_BIT];
      end
   end

   // ***************************************************************
   // Rotate on automatic end of interrupt, master only.
   // ***************************************************************
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rotate_auto_eoi_mirror_reg <= 1'b0;
      end else if (raeoi_set) begin
         rotate_auto_eoi_mirror_reg <= 1'b1;
      end else if (raeoi_clr) begin
         rotate_auto_eoi_mirror_reg <= 1'b0;
      end
   end

   // ***************************************************************
   // Clock index port capture.
   // ***************************************************************
   logic [7:0] rtc_index_mirror_reg;
   wire logic rtc_index_wr =
      io_req.wr && io_req.addr == srss_pkg::SRSS_RTC_INDEX_IO_ADDR;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rtc_index_mirror_reg <= srss_pkg::SRSS_RTC_INDEX_RESET;
      end else if (rtc_index_wr) begin
         rtc_index_mirror_reg <= io_req.wdata[7:0];
      end
   end

   // ***************************************************************
   // Timing references.
   // ***************************************************************
   logic ref_prev_reg;
   logic half_refresh_ref_tick_reg;
   logic refresh_toggle_reg;
   wire logic ref_rise = refresh_ref_input & ~ref_prev_reg;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ref_prev_reg <= 1'b0;
         half_refresh_ref_tick_reg <= 1'b0;
         refresh_toggle_reg <= 1'b0;
      end else begin
         ref_prev_reg <= refresh_ref_input;
         if (ref_rise) begin
            half_refresh_ref_tick_reg <= ~half_refresh_ref_tick_reg;
         end
         if (refresh_cycle) begin
            refresh_toggle_reg <= ~refresh_toggle_reg;
         end
      end
   end

   // ***************************************************************
   // Recent bus master activity window.
   // ***************************************************************
   localparam logic [15:0] NO_DMA_LAST = 16'(NO_DMA_CYCLES - 1);
   logic [15:0] no_dma_count_reg;
   logic no_recent_bus_master_reg;
   wire logic no_dma_expired = no_dma_count_reg == NO_DMA_LAST;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         no_dma_count_reg <= 16'h0000;
         no_recent_bus_master_reg <= 1'b0;
      end else if (bus_master_cycle) begin
         no_dma_count_reg <= 16'h0000;
         no_recent_bus_master_reg <= 1'b0;
      end else if (no_dma_expired) begin
         no_recent_bus_master_reg <= 1'b1;
      end else begin
         no_dma_count_reg <= no_dma_count_reg + 16'h0001;
      end
   end

   // ***************************************************************
   // Register images.
   // ***************************************************************
   logic [15:0] nmi_status_image;
   logic [15:0] port_shadow_image;
   logic [15:0] irq_shadow_image;
   logic [15:0] rtc_shadow_image;

   always_comb begin
      nmi_status_image = 16'h0000;
      nmi_status_image[srss_pkg::SRSS_NMI_FLAGS_LSB +: 6] =
         nmi_cause_flags;
   end

   assign port_shadow_image = {
      port_view.serial_a_reg2_mirror,
      port_view.serial_b_reg2_mirror,
      port_view.parallel_reg2_mirror,
      port_view.parallel_reg0_mirror
   };

   always_comb begin
      irq_shadow_image = 16'h0000;
      irq_shadow_image[srss_pkg::SRSS_IRQ_TIMEOUT_BIT] =
         idle_timeout_compare;
      irq_shadow_image[srss_pkg::SRSS_IRQ_IDENT_LSB +: 2] =
         DEVICE_IDENT;
      irq_shadow_image[srss_pkg::SRSS_IRQ_MVEC_BIT] =
         vector_msb[0];
      irq_shadow_image[srss_pkg::SRSS_IRQ_SVEC_BIT] =
         vector_msb[1];
      irq_shadow_image[srss_pkg::SRSS_IRQ_SPECIAL_NESTED_MIRROR_BIT] =
         special_nested_mirror_reg;
      irq_shadow_image[srss_pkg::SRSS_IRQ_AEOI_BIT] =
         auto_eoi_mirror_reg;
      irq_shadow_image[srss_pkg::SRSS_IRQ_RAEOI_BIT] =
         rotate_auto_eoi_mirror_reg;
      irq_shadow_image[srss_pkg::SRSS_IRQ_MPRI_LSB +: 3] =
         lowest_priority[0];
      irq_shadow_image[srss_pkg::SRSS_IRQ_SPRI_LSB +: 3] =
         lowest_priority[1];
      irq_shadow_image[srss_pkg::SRSS_IRQ_MSMM_BIT] =
         special_mask[0];
      irq_shadow_image[srss_pkg::SRSS_IRQ_SSMM_BIT] =
         special_mask[1];
   end

   assign rtc_shadow_image = {
      half_refresh_ref_tick_reg,
      refresh_toggle_reg,
      cpu_irq_level,
      no_recent_bus_master_reg,
      srss_pkg::SRSS_RTC_RESERVED_RESET,
      rtc_index_mirror_reg
   };

   // ***************************************************************
   // Read decode; reads change no state.
   // ***************************************************************
   wire logic hit_nmi =
      io_req.addr == srss_pkg::SRSS_NMI_CAUSE_STATUS_ADDR;
   wire logic hit_port = io_req.addr == srss_pkg::SRSS_PORT_SHADOW_ADDR;
   wire logic hit_irq = io_req.addr == srss_pkg::SRSS_IRQ_SHADOW_ADDR;
   wire logic hit_rtc = io_req.addr == srss_pkg::SRSS_RTC_SHADOW_ADDR;
   logic [15:0] read_mux;
   logic read_claim;

   always_comb begin
      read_mux = 16'h0000;
      read_claim = 1'b0;
      if (hit_rtc) begin
         read_mux = rtc_shadow_image;
         read_claim = 1'b1;
      end else if (!ext_regs_unlocked) begin
         read_mux = 16'h0000;
         read_claim = 1'b0;
      end else if (hit_nmi) begin
         read_mux = nmi_status_image;
         read_claim = 1'b1;
      end else if (hit_port) begin
         read_mux = port_shadow_image;
         read_claim = 1'b1;
      end else if (hit_irq) begin
         read_mux = irq_shadow_image;
         read_claim = 1'b1;
      end
   end

   // ***************************************************************
   // Registered read answer.
   // ***************************************************************
   logic [15:0] rdata_reg;
   logic rdata_valid_reg;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rdata_valid_reg <= 1'b0;
      end else begin
         rdata_valid_reg <= io_req.rd & read_claim;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rdata_reg <= 16'h0000;
      end else if (io_req.rd) begin
         rdata_reg <= read_mux;
      end
   end

   assign io_rdata = rdata_reg;
   assign io_rdata_valid = rdata_valid_reg;

endmodule : srss_top

`default_nettype wire

/* suspend_resume_shadow_status_tb.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
   n_mismatch++; $display("unexpected %s exp %h got %h", nm, ex, gt); end end

module suspend_resume_shadow_status_tb;
   // ***************************************************************
   // Stimulus.
   // ***************************************************************
   logic sys_clk = 1'b0, reset = 1'b1, ext_regs_unlocked = 1'b0;
   srss_pkg::srss_io_req_t io_req = '0;
   srss_pkg::srss_port_view_t port_view = '0;
   srss_pkg::srss_pic_wr_t pic_master_wr = '0, pic_slave_wr = '0;
   logic [15:0] io_rdata;
   logic io_rdata_valid, nmi_request, local_attention_request;
   logic [5:0] pm_inputs = '0, nmi_source_enables = '0;
   logic [5:0] local_attention_enables = '0;
   logic [5:0] nmi_cause_flags, local_attention_flags, pm_input_status;
   logic idle_timeout_compare = 1'b0, refresh_ref_input = 1'b0;
   logic refresh_cycle = 1'b0, cpu_irq_level = 1'b0;
   logic bus_master_cycle = 1'b0;
   int n_mismatch = 0, n_tests = 0, cyc = 0;

   srss_top #(.NO_DMA_CYCLES(8), .DEVICE_IDENT(2'h2)) u_dut (.sys_clk,
      .reset, .io_req, .ext_regs_unlocked, .io_rdata, .io_rdata_valid,
      .pm_inputs, .nmi_source_enables, .local_attention_enables,
      .nmi_cause_flags, .local_attention_flags, .pm_input_status,
      .nmi_request, .local_attention_request, .port_view, .pic_master_wr,
      .pic_slave_wr, .idle_timeout_compare, .refresh_ref_input,
      .refresh_cycle, .cpu_irq_level, .bus_master_cycle);

   always #2 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         summarize();
      end
   end

   task summarize;
      $display("mismatches %0d tests %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize

   task chk(input logic [15:0] a, input logic ok, input logic [15:0] ex);
      @(negedge sys_clk);
      io_req.rd = 1'b1;
      io_req.addr = a;
      @(negedge sys_clk);
      io_req.rd = 1'b0;
      `CHK("read valid", ok, io_rdata_valid)
      `CHK("read data", ex, io_rdata)
   endtask : chk

   task wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge sys_clk);
      io_req.wr = 1'b1;
      io_req.addr = a;
      io_req.wdata = d;
      @(negedge sys_clk);
      io_req.wr = 1'b0;
   endtask : wr

   task pic(input bit s, input logic [3:0] k, input logic [7:0] d);
      @(negedge sys_clk);
      if (s)
         pic_slave_wr = {k, d};
      else
         pic_master_wr = {k, d};
      @(negedge sys_clk);
      pic_slave_wr = '0;
      pic_master_wr = '0;
   endtask : pic

   task pulse_timing;
      refresh_cycle = 1'b1;
      @(negedge sys_clk);
      refresh_cycle = 1'b0;
      refresh_ref_input = 1'b1;
      @(negedge sys_clk);
      refresh_ref_input = 1'b0;
   endtask : pulse_timing

   initial begin
      repeat (3) @(negedge sys_clk);
      reset = 1'b0;
      repeat (10) @(negedge sys_clk);
      chk(16'hE472, 1'b1, 16'h1080);
      chk(16'hD072, 1'b0, 16'h0000);
      chk(16'h1234, 1'b0, 16'h0000);
      ext_regs_unlocked = 1'b1;
      wr(16'h0070, 16'hAB05);
      chk(16'hE472, 1'b1, 16'h1005);
      wr(16'h9072, 16'h00FC);
      chk(16'h9072, 1'b1, 16'h0000);
      bus_master_cycle = 1'b1;
      @(negedge sys_clk);
      bus_master_cycle = 1'b0;
      chk(16'hE472, 1'b1, 16'h0005);
      repeat (12) @(negedge sys_clk);
      chk(16'hE472, 1'b1, 16'h1005);
      cpu_irq_level = 1'b1;
      pulse_timing();
      chk(16'hE472, 1'b1, 16'hF005);
      cpu_irq_level = 1'b0;
      pulse_timing();
      chk(16'hE472, 1'b1, 16'h1005);
      port_view = 16'hAAAA;
      chk(16'hD072, 1'b1, 16'hAAAA);
      port_view = 16'h5C3A;
      chk(16'hD072, 1'b1, 16'h5C3A);
      idle_timeout_compare = 1'b1;
      pic(0, 4'h8, 8'h80);
      pic(1, 4'h8, 8'h80);
      pic(0, 4'h4, 8'h12);
      pic(1, 4'h4, 8'h12);
      pic(0, 4'h2, 8'h80);
      pic(0, 4'h2, 8'hC5);
      pic(1, 4'h2, 8'hC3);
      pic(1, 4'h2, 8'h80);
      pic(0, 4'h1, 8'h60);
      pic(1, 4'h1, 8'h60);
      chk(16'hD472, 1'b1, 16'hDFAF);
      idle_timeout_compare = 1'b0;
      pic(0, 4'h2, 8'h00);
      pic(0, 4'h1, 8'h40);
      chk(16'hD472, 1'b1, 16'h5EAD);
      pm_inputs = 6'h20;
      repeat (3) @(negedge sys_clk);
      nmi_source_enables = 6'h21;
      pm_inputs = 6'h03;
      repeat (3) @(negedge sys_clk);
      `CHK("cause flags", 6'h01, nmi_cause_flags)
      `CHK("nmi request", 1'b1, nmi_request)
      chk(16'h9072, 1'b1, 16'h0004);
      local_attention_enables = 6'h01;
      pm_inputs = 6'h00;
      repeat (3) @(negedge sys_clk);
      `CHK("input status", 1'b1, pm_input_status[0])
      `CHK("attention flags", 6'h01, local_attention_flags)
      `CHK("attention request", 1'b1, local_attention_request)
      nmi_source_enables = 6'h00;
      repeat (2) @(negedge sys_clk);
      `CHK("cause flags", 6'h01, nmi_cause_flags)
      `CHK("input status", 1'b1, pm_input_status[0])
      local_attention_enables = 6'h00;
      repeat (2) @(negedge sys_clk);
      `CHK("cause flags", 6'h00, nmi_cause_flags)
      `CHK("input status", 1'b0, pm_input_status[0])
      `CHK("attention flags", 6'h00, local_attention_flags)
      reset = 1'b1;
      repeat (2) @(negedge sys_clk);
      reset = 1'b0;
      chk(16'hE472, 1'b1, 16'h0080);
      summarize();
   end
endmodule : suspend_resume_shadow_status_tb

`default_nettype wire
